//--- hdl/smx_core.sv
// SMBus extension: timeouts, packet check, alert, special addresses
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Function
// - Per-byte ACK control lets software ack or nack each received data byte except the check byte.
// - Host address accepted when enabled, for host notify as slave.
// - Default device, host and alert response addresses each need their enable.
// - SCL low beyond (reload+1)*2048 cycles sets timeout flag.
// - Primary reload and idle select locked while primary timer enabled.
// - Own cumulative stretching beyond (reload+1)*2048 cycles sets timeout flag.
// - Stretch reload locked while stretch timer enabled.
// - SCL and SDA high beyond (reload+1)*4 cycles sets timeout flag.
// - Check byte is CRC-8 x^8+x^2+x+1 from zero, address included.
// - One check byte appended at transfer end when checking is used.
// - Check byte follows byte count minus one data bytes.
// - Check-send ignored while count-reload mode is active.
// - Slave role alert enable pulls alert pin low, accepts alert address.
// - Host role: alert falling edge sets alert flag, error interrupt.
// - Alert disabled means alert line reads high whatever the pin.
// - Check byte mismatch sets mismatch flag and error interrupt.
module smx_core import smx_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic alert_pin_i,
    output logic alert_pin_o,
    output logic alert_pin_oe_o,
    input wire smx_byte_ev_t byte_ev_i,
    input wire logic own_stretch_i,
    input wire logic frame_end_i,
    output smx_eng_out_t eng_o,
    output logic [7:0] pec_byte_o,
    output logic err_irq_o
);
    logic [CTRL_W-1:0] ctrl_q;
    smx_tmo_cfg_t tmo_q;
    logic [2:0] stat_q;
    logic [7:0] cnt_q;
    logic [7:0] left_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic alert_prev_q;
    logic [2:0] pin_raw;
    logic scl_s;
    logic sda_s;
    logic alert_lvl;
    logic alert_fall;
    logic host_role;
    logic pec_mode;
    logic wr_ctrl;
    logic wr_tmo;
    logic wr_stat;
    logic wr_cnt;
    logic wr_ack;
    logic ev_addr;
    logic ev_data;
    logic pec_hit;
    logic pec_bad;
    logic prim_hit;
    logic ext_hit;
    logic prim_cond;
    logic [6:0] ev_adr7;
    logic [2:0] stat_set;
    logic [31:0] rd_d;

    // Bus write decode
    assign wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;
    assign wr_tmo = reg_wr_i && reg_addr_i == OFS_TMO;
    assign wr_stat = reg_wr_i && reg_addr_i == OFS_STAT;
    assign wr_cnt = reg_wr_i && reg_addr_i == OFS_CNT;
    assign wr_ack = reg_wr_i && reg_addr_i == OFS_ACK;

    // Pin synchronisers: first stage feeds only the second
    assign pin_raw = {alert_pin_i, sda_i, scl_i};
    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    sync1_q[g] <= 1'b1;
                    sync2_q[g] <= 1'b1;
                end else if (ce_i) begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate
    assign scl_s = sync2_q[0];
    assign sda_s = sync2_q[1];

    // Control register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= CTRL_RST;
        end else if (ce_i && wr_ctrl) begin
            ctrl_q <= reg_wdata_i[CTRL_W-1:0];
            if (ctrl_q[C_PEN]) ctrl_q[C_PCEN] <= ctrl_q[C_PCEN];
        end
    end
    assign host_role = ctrl_q[C_HAEN];
    assign pec_mode = ctrl_q[C_PCEN] && ctrl_q[C_PSND] && !ctrl_q[C_RLD];

    // Timeout configuration register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tmo_q <= '{1'b0, RELOAD_RST, 1'b0, 1'b0, RELOAD_RST};
        end else if (ce_i && wr_tmo) begin
            tmo_q.primary_en <= reg_wdata_i[15];
            tmo_q.stretch_en <= reg_wdata_i[31];
            if (!tmo_q.primary_en) begin
                tmo_q.primary_reload <= reg_wdata_i[11:0];
                tmo_q.idle_sel <= reg_wdata_i[12];
            end
            if (!tmo_q.stretch_en) begin
                tmo_q.stretch_reload <= reg_wdata_i[27:16];
            end
        end
    end

    // Byte count register
    always_ff @(posedge clk_i) begin
        if (reset_i) cnt_q <= CNT_RST;
        else if (ce_i && wr_cnt) cnt_q <= reg_wdata_i[7:0];
    end

    // Primary timer, SCL low or idle
    assign prim_cond = tmo_q.idle_sel ? (scl_s && sda_s) : !scl_s;
    smx_tmo_cnt u_prim (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .en_i(tmo_q.primary_en),
        .cond_i(prim_cond),
        .clr_i(!prim_cond),
        .short_unit_i(tmo_q.idle_sel),
        .reload_i(tmo_q.primary_reload),
        .hit_o(prim_hit)
    );
    smx_tmo_cnt u_ext (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .en_i(tmo_q.stretch_en),
        .cond_i(own_stretch_i),
        .clr_i(frame_end_i),
        .short_unit_i(1'b0),
        .reload_i(tmo_q.stretch_reload),
        .hit_o(ext_hit)
    );

    // Byte events
    assign ev_addr = byte_ev_i.valid && byte_ev_i.addr;
    assign ev_data = byte_ev_i.valid && !byte_ev_i.addr;
    assign ev_adr7 = byte_ev_i.data[7:1];
    assign pec_hit = ev_data && eng_o.pec_slot && byte_ev_i.rx;
    assign pec_bad = pec_hit && byte_ev_i.data != pec_byte_o;

    // CRC restarts at the address byte
    smx_crc8 u_crc (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .clr_i(ev_addr),
        .upd_i(byte_ev_i.valid),
        .data_i(byte_ev_i.data),
        .crc_o(pec_byte_o)
    );

    // Count down to the check byte
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            left_q <= CNT_RST;
            eng_o.pec_slot <= 1'b0;
        end else if (ce_i) begin
            if (!pec_mode) begin
                eng_o.pec_slot <= 1'b0;
            end else if (ev_addr) begin
                left_q <= cnt_q;
                eng_o.pec_slot <= cnt_q == 8'h01;
            end else if (ev_data && eng_o.pec_slot) begin
                eng_o.pec_slot <= 1'b0;
                left_q <= 8'h00;
            end else if (ev_data && left_q != 8'h00) begin
                left_q <= left_q - 8'h01;
                eng_o.pec_slot <= left_q == 8'h02;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eng_o.special_hit <= 1'b0;
        end else if (ce_i && ev_addr) begin
            eng_o.special_hit <=
                (ctrl_q[C_DAEN] && ev_adr7 == ADDR_DEF_DEV) ||
                (host_role && ev_adr7 == ADDR_HOST) ||
                (!host_role && ctrl_q[C_ALEN] && ev_adr7 == ADDR_ALERT);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eng_o.ack_pending <= 1'b0;
            eng_o.ack_value <= 1'b1;
        end else if (ce_i) begin
            if (pec_hit) begin
                eng_o.ack_pending <= 1'b0;
                eng_o.ack_value <= !pec_bad;
            end else if (ev_data && byte_ev_i.rx && ctrl_q[C_PBAC]) begin
                eng_o.ack_pending <= 1'b1;
            end else if (ev_data && byte_ev_i.rx) begin
                eng_o.ack_value <= 1'b1;
            end else if (wr_ack) begin
                eng_o.ack_pending <= 1'b0;
                eng_o.ack_value <= reg_wdata_i[0];
            end
        end
    end

    // Alert line forced high when disabled
    assign alert_lvl = ctrl_q[C_ALEN] ? sync2_q[2] : 1'b1;
    assign alert_fall = alert_prev_q && !alert_lvl;
    always_ff @(posedge clk_i) begin
        if (reset_i) alert_prev_q <= 1'b1;
        else if (ce_i) alert_prev_q <= alert_lvl;
    end

    // Slave pulls the alert pin low
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            alert_pin_o <= 1'b0;
            alert_pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            alert_pin_o <= 1'b0;
            alert_pin_oe_o <= !host_role && ctrl_q[C_ALEN];
        end
    end

    // Status flags: set wins over write-one clear
    assign stat_set[S_TMO] = prim_hit || ext_hit;
    assign stat_set[S_ALR] = host_role && alert_fall;
    assign stat_set[S_PEC] = pec_bad;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stat_q <= 3'h0;
        end else if (ce_i) begin
            stat_q <= (stat_q & ~(wr_stat ? reg_wdata_i[2:0] : 3'h0)) | stat_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) err_irq_o <= 1'b0;
        else if (ce_i) err_irq_o <= ctrl_q[C_EIE] && (|stat_q);
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        case (reg_addr_i)
            OFS_CTRL: rd_d = {22'h000000, ctrl_q};
            OFS_TMO: rd_d = {tmo_q.stretch_en, 3'h0, tmo_q.stretch_reload,
                             tmo_q.primary_en, 2'h0, tmo_q.idle_sel, tmo_q.primary_reload};
            OFS_STAT: rd_d = {29'h00000000, stat_q};
            OFS_PEC: rd_d = {24'h000000, pec_byte_o};
            OFS_CNT: rd_d = {16'h0000, left_q, cnt_q};
            OFS_ACK: rd_d = {30'h00000000, eng_o.ack_pending, eng_o.ack_value};
            default: rd_d = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) reg_rdata_o <= 32'h00000000;
        else if (ce_i) reg_rdata_o <= reg_rd_i ? rd_d : 32'h00000000;
    end

    // Checks
    property p_def_addr;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && ev_addr && ev_adr7 == ADDR_DEF_DEV |=> eng_o.special_hit == $past(ctrl_q[C_DAEN]);
    endproperty
    a_def_addr: assert property (p_def_addr) else $error("default address match wrong");

    property p_host_addr;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && ev_addr && ev_adr7 == ADDR_HOST |=> eng_o.special_hit == $past(host_role);
    endproperty
    a_host_addr: assert property (p_host_addr) else $error("host address match wrong");

    property p_prim_lock;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && tmo_q.primary_en |=> $stable(tmo_q.primary_reload) && $stable(tmo_q.idle_sel);
    endproperty
    a_prim_lock: assert property (p_prim_lock) else $error("primary reload changed");

    property p_ext_lock;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && tmo_q.stretch_en |=> $stable(tmo_q.stretch_reload);
    endproperty
    a_ext_lock: assert property (p_ext_lock) else $error("stretch reload changed");

    property p_tmo_flag;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && (prim_hit || ext_hit) |=> stat_q[S_TMO];
    endproperty
    a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag not set");

    property p_reload_mask;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && ctrl_q[C_RLD] ##1 ce_i |=> !eng_o.pec_slot;
    endproperty
    a_reload_mask: assert property (p_reload_mask) else $error("check slot in reload");

    property p_alert_off;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !ctrl_q[C_ALEN] && !stat_q[S_ALR] |=> !stat_q[S_ALR];
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("alert set while disabled");

    property p_alert_edge;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && host_role && ctrl_q[C_ALEN] && alert_prev_q && !sync2_q[2] |=> stat_q[S_ALR];
    endproperty
    a_alert_edge: assert property (p_alert_edge) else $error("alert edge missed");

    property p_pec_err;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && pec_bad |=> stat_q[S_PEC] && !eng_o.ack_value;
    endproperty
    a_pec_err: assert property (p_pec_err) else $error("mismatch not flagged");

    property p_ack_hold;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && eng_o.ack_pending && !wr_ack && !pec_hit |=> eng_o.ack_pending;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack decision lost");

    property p_alert_pull;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !host_role && ctrl_q[C_ALEN] ##1 ce_i |-> alert_pin_oe_o && !alert_pin_o;
    endproperty
    a_alert_pull: assert property (p_alert_pull) else $error("alert pin not pulled");
endmodule

//--- hdl/smx_crc8.sv
// Byte-wide CRC-8 accumulator for the packet check byte
`timescale 1ns/1ps
module smx_crc8 import smx_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic upd_i,
    input wire logic [7:0] data_i,
    output logic [7:0] crc_o
);
    logic [7:0] base;
    logic [7:0] nxt;
    // Shift one byte through the polynomial, MSB first
    always_comb begin
        base = clr_i ? CRC_INIT : crc_o;
        nxt = base ^ data_i;
        for (int i = 0; i < 8; i++) begin
            nxt = nxt[7] ? ((nxt << 1) ^ CRC_POLY) : (nxt << 1);
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            crc_o <= CRC_INIT;
        end else if (ce_i) begin
            if (upd_i) crc_o <= nxt;
            else if (clr_i) crc_o <= CRC_INIT;
        end
    end
    property p_crc_single;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && clr_i && upd_i && data_i == 8'h01 |=> crc_o == 8'h07;
    endproperty
    a_crc_single: assert property (p_crc_single) else $error("crc of 01 wrong");
endmodule

//--- hdl/smx_tmo_cnt.sv
// Prescaled timeout counter with pause and restart
`timescale 1ns/1ps
module smx_tmo_cnt import smx_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic en_i,
    input wire logic cond_i,
    input wire logic clr_i,
    input wire logic short_unit_i,
    input wire logic [11:0] reload_i,
    output logic hit_o
);
    logic [10:0] pre_q;
    logic [11:0] unit_q;
    logic done_q;
    logic unit_end;
    logic last;
    assign unit_end = pre_q == (short_unit_i ? IDLE_UNIT_LAST : LOW_UNIT_LAST);
    assign last = cond_i && !done_q && unit_end && unit_q == reload_i;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_q <= 11'h000;
            unit_q <= 12'h000;
            done_q <= 1'b0;
        end else if (ce_i) begin
            if (!en_i || clr_i) begin
                pre_q <= 11'h000;
                unit_q <= 12'h000;
                done_q <= 1'b0;
            end else if (cond_i && !done_q) begin
                pre_q <= unit_end ? 11'h000 : pre_q + 11'h001;
                if (unit_end && unit_q == reload_i) done_q <= 1'b1;
                else if (unit_end) unit_q <= unit_q + 12'h001;
            end
        end
    end
    // One pulse per expired interval
    always_ff @(posedge clk_i) begin
        if (reset_i) hit_o <= 1'b0;
        else if (ce_i) hit_o <= en_i && !clr_i && last;
    end
    property p_tmo_restart;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && en_i && clr_i |=> pre_q == 11'h000 && unit_q == 12'h000 && !hit_o;
    endproperty
    a_tmo_restart: assert property (p_tmo_restart) else $error("timer not restarted");
endmodule

//--- inc/smx_pkg.sv
// Shared constants and types for the SMBus extension block
package smx_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TMO = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_PEC = 8'h0C;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_ACK = 8'h14;
    // Control register fields
    localparam int C_PBAC = 0;
    localparam int C_HAEN = 1;
    localparam int C_DAEN = 2;
    localparam int C_ALEN = 3;
    localparam int C_PCEN = 4;
    localparam int C_PSND = 5;
    localparam int C_RLD = 6;
    localparam int C_ASTP = 7;
    localparam int C_EIE = 8;
    localparam int C_PEN = 9;
    localparam int CTRL_W = 10;
    // Status register fields, write one to clear
    localparam int S_TMO = 0;
    localparam int S_ALR = 1;
    localparam int S_PEC = 2;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [11:0] RELOAD_RST = 12'h000;
    localparam logic [7:0] CNT_RST = 8'h00;
    // Fixed SMBus addresses, seven bits
    localparam logic [6:0] ADDR_DEF_DEV = 7'h61;
    localparam logic [6:0] ADDR_HOST = 7'h08;
    localparam logic [6:0] ADDR_ALERT = 7'h0C;
    // CRC-8, x^8+x^2+x+1, start value zero
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // Timeout units in kernel clock cycles, as last prescaler count
    localparam logic [10:0] LOW_UNIT_LAST = 11'h7FF;
    localparam logic [10:0] IDLE_UNIT_LAST = 11'h003;
    // Byte event from the serial engine
    typedef struct packed {
        logic valid;
        logic addr;
        logic rx;
        logic [7:0] data;
    } smx_byte_ev_t;
    // Decisions handed back to the serial engine
    typedef struct packed {
        logic special_hit;
        logic ack_pending;
        logic ack_value;
        logic pec_slot;
    } smx_eng_out_t;
    // Timeout configuration
    typedef struct packed {
        logic stretch_en;
        logic [11:0] stretch_reload;
        logic primary_en;
        logic idle_sel;
        logic [11:0] primary_reload;
    } smx_tmo_cfg_t;
endpackage

//--- verif/smx_bus_peer.sv
// Far-side bus model: clock and data lines plus the shared alert line
`timescale 1ns/1ps
module smx_bus_peer (
    input wire logic frame_i,
    input wire logic hold_low_i,
    input wire logic alert_pull_i,
    input wire logic alert_oe_i,
    output logic scl_o,
    output logic sda_o,
    output logic alert_o
);
    logic link_q = 1'h1;
    logic bit_q = 1'h1;
    // Link clock of 160 ns, still and high outside frames
    initial begin
        #3;
        forever #80 link_q = frame_i ? ~link_q : 1'h1;
    end
    // Data pattern flips on every falling link edge
    always @(negedge link_q) bit_q <= ~bit_q;
    // Released lines go to the pull-up level
    assign scl_o = hold_low_i ? 1'h0 : link_q;
    assign sda_o = frame_i ? bit_q : 1'h1;
    // Open-drain alert, any puller wins
    assign alert_o = ~(alert_pull_i | alert_oe_i);
endmodule

//--- verif/tb.sv
// Self-checking bench for the SMBus extension core
`timescale 1ns/1ps
module tb;
    import smx_pkg::*;
    typedef struct {string nm; logic [31:0] e; logic [31:0] m;} smx_note_t;
    localparam logic [6:0] spec_addr [3] = '{ADDR_DEF_DEV, ADDR_HOST, ADDR_ALERT};
    localparam int spec_bit [3] = '{C_DAEN, C_HAEN, C_ALEN};
    logic clk = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic rd_q = 1'h0;
    logic frame = 1'h0;
    logic hold = 1'h0;
    logic pull = 1'h0;
    logic stretch = 1'h0;
    logic ce = 1'h1;
    logic fend = 1'h0;
    logic [31:0] rdata;
    logic scl;
    logic sda;
    logic alert;
    logic alert_o;
    logic alert_oe;
    logic irq;
    smx_byte_ev_t ev = '0;
    smx_eng_out_t eng;
    logic [7:0] pec;
    logic [7:0] crc = 8'h00;
    logic [7:0] pe;
    logic [31:0] seed = 32'hD560;
    int bad_count = 0;
    int checked = 0;
    smx_note_t notes[$];
    smx_note_t n;
    always #4 clk = ~clk;
    smx_core u_smx_core (.clk_i(clk), .reset_i(reset_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .scl_i(scl), .sda_i(sda), .alert_pin_i(alert),
        .alert_pin_o(alert_o), .alert_pin_oe_o(alert_oe), .byte_ev_i(ev),
        .own_stretch_i(stretch), .frame_end_i(fend), .eng_o(eng),
        .pec_byte_o(pec), .err_irq_o(irq));
    smx_bus_peer u_smx_bus_peer (.frame_i(frame), .hold_low_i(hold),
        .alert_pull_i(pull), .alert_oe_i(alert_oe), .scl_o(scl), .sda_o(sda),
        .alert_o(alert));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
        end
        return x;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rst();
        @(posedge clk);
        reset_i <= 1'h1;
        repeat (8) @(posedge clk);
        reset_i <= 1'h0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        notes.push_back('{nm, e & m, m});
        @(posedge clk);
        rd <= 1'h0;
    endtask
    // One byte event; the model CRC restarts on an address byte
    task automatic send(input logic a, input logic [7:0] d);
        @(posedge clk);
        ev <= '{1'h1, a, 1'h1, d};
        @(posedge clk);
        ev.valid <= 1'h0;
        crc = crc8(a ? 8'h00 : crc, d);
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Read data watcher: the oldest note is due the cycle after a read
    always @(posedge clk) begin
        if (rd_q) begin
            n = notes.pop_front();
            chk(n.nm, n.e, rdata & n.m);
        end else if (!reset_i) begin
            // Read data must fall back to zero outside the answer cycle
            chk("rdata_idle", 32'h0, rdata);
        end
        rd_q <= rd;
    end
    // Watchdog, about four times the expected run
    initial begin
        #300000;
        bad_count++;
        finish_test();
    end
    // Main sequence
    initial begin
        rst();
        rd_reg(OFS_CTRL, 32'h0, 32'hFFFFFFFF, "ctrl");
        rd_reg(OFS_TMO, 32'h0, 32'hFFFFFFFF, "tmo");
        rd_reg(8'h40, 32'h0, 32'hFFFFFFFF, "unmapped");
        // Low timeout: reload 0 gives 2048 cycles, toggling never trips
        wr_reg(OFS_TMO, 32'h00008000);
        wr_reg(OFS_TMO, 32'h00009ABC);
        rd_reg(OFS_TMO, 32'h00008000, 32'h0000FFFF, "tmo_lock");
        frame <= 1'h1;
        wait_cyc(2600);
        frame <= 1'h0;
        rd_reg(OFS_STAT, 32'h0, 32'h1, "toggle");
        hold <= 1'h1;
        wait_cyc(2040);
        rd_reg(OFS_STAT, 32'h0, 32'h1, "low_early");
        wait_cyc(40);
        rd_reg(OFS_STAT, 32'h1, 32'h1, "low_late");
        hold <= 1'h0;
        wr_reg(OFS_STAT, 32'h1);
        rd_reg(OFS_STAT, 32'h0, 32'h1, "clear");
        $display("test low_timeout done");
        // Idle detect, reload 2 gives 12 cycles
        rst();
        wr_reg(OFS_TMO, 32'h00009002);
        // Clock enable low must freeze the idle count
        ce <= 1'h0;
        wait_cyc(20);
        ce <= 1'h1;
        rd_reg(OFS_STAT, 32'h0, 32'h1, "idle_early");
        wait_cyc(20);
        rd_reg(OFS_STAT, 32'h1, 32'h1, "idle_late");
        $display("test idle done");
        // Cumulative stretching over two bursts
        rst();
        wr_reg(OFS_TMO, 32'h80000000);
        wr_reg(OFS_TMO, 32'h80050000);
        rd_reg(OFS_TMO, 32'h80000000, 32'hFFFF0000, "str_lock");
        stretch <= 1'h1;
        wait_cyc(1100);
        stretch <= 1'h0;
        wait_cyc(50);
        rd_reg(OFS_STAT, 32'h0, 32'h1, "str_part");
        stretch <= 1'h1;
        wait_cyc(1000);
        stretch <= 1'h0;
        wait_cyc(10);
        rd_reg(OFS_STAT, 32'h1, 32'h1, "str_sum");
        // Frame end restarts the sum, so a fresh long stretch trips again
        wr_reg(OFS_STAT, 32'h1);
        fend <= 1'h1;
        wait_cyc(1);
        fend <= 1'h0;
        stretch <= 1'h1;
        wait_cyc(2100);
        stretch <= 1'h0;
        rd_reg(OFS_STAT, 32'h1, 32'h1, "str_frame");
        $display("test stretch done");
        // Packet check with count 3, count-reload off then on
        for (int m = 0; m < 2; m++) begin
            rst();
            wr_reg(OFS_CTRL, 32'h131 | 32'(m << C_RLD));
            wr_reg(OFS_CNT, 32'h3);
            seed = lfsr(seed);
            send(1'h1, (m == 1) ? 8'h01 : {seed[7:1], 1'h0});
            chk("slot_addr", 32'h0, eng.pec_slot);
            seed = lfsr(seed);
            send(1'h0, seed[7:0]);
            chk("pending", 32'h1, eng.ack_pending);
            wr_reg(OFS_ACK, 32'h0);
            @(negedge clk);
            chk("nack", 32'h0, eng.ack_value);
            seed = lfsr(seed);
            send(1'h0, seed[7:0]);
            pe = crc;
            chk("slot", 32'(m == 0), eng.pec_slot);
            chk("crc", 32'(pe), pec);
            wr_reg(OFS_ACK, 32'h1);
            rd_reg(OFS_PEC, 32'(pe), 32'hFF, "pec_reg");
            if (m == 0) begin
                send(1'h0, pe ^ 8'h5A);
                chk("pec_ack", 32'h0, eng.ack_value);
                rd_reg(OFS_STAT, 32'h4, 32'h4, "pec_flag");
                @(negedge clk);
                chk("irq", 32'h1, irq);
            end
        end
        $display("test packet_check done");
        // Special addresses, each with its enable off and on
        rst();
        for (int i = 0; i < 6; i++) begin
            wr_reg(OFS_CTRL, 32'(i % 2) << spec_bit[i / 2]);
            send(1'h1, {spec_addr[i / 2], 1'h0});
            chk("special", 32'(i % 2), eng.special_hit);
            chk("alert_drv", 32'(i == 5), alert_oe);
            chk("alert_out", 32'h0, alert_o);
        end
        // Calc enable stays put once the peripheral is enabled
        wr_reg(OFS_CTRL, 32'h210);
        wr_reg(OFS_CTRL, 32'h200);
        rd_reg(OFS_CTRL, 32'h210, 32'h3FF, "calc_lock");
        $display("test addresses done");
        // Host role alert, then alert disabled
        rst();
        wr_reg(OFS_CTRL, 32'h10A);
        @(negedge clk);
        chk("alert_host", 32'h0, alert_oe);
        @(posedge clk);
        pull <= 1'h1;
        wait_cyc(10);
        rd_reg(OFS_STAT, 32'h2, 32'h2, "alert_flag");
        @(negedge clk);
        chk("irq_alert", 32'h1, irq);
        @(posedge clk);
        pull <= 1'h0;
        wr_reg(OFS_STAT, 32'h2);
        wr_reg(OFS_CTRL, 32'h102);
        @(posedge clk);
        pull <= 1'h1;
        wait_cyc(10);
        rd_reg(OFS_STAT, 32'h0, 32'h2, "alert_off");
        $display("test alert done");
        wait_cyc(3);
        finish_test();
    end
endmodule
